/* File: hdl/psf_pkg.sv */
package psf_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and time base
	localparam int PSF_CLK_NS   = 50;
	localparam int PSF_TICK_US  = 1000;
	localparam int PSF_TICK_CYC = PSF_TICK_US * 1000 / PSF_CLK_NS;

	////////////////////////////////////////////////////////////////////////
	// intervals in ms and in time base ticks
	localparam int PSF_FLT_MS   = 32;
	localparam int PSF_SURGE_MS = 128;
	localparam int PSF_SAG_MS   = 32;
	localparam int PSF_RETRY_MS = 128;
	localparam int PSF_REARM_MS = 128;
	localparam int PSF_RAMP_MS  = 15;

	localparam logic [7:0] PSF_FLT_TICKS   = 8'(PSF_FLT_MS * 1000 / PSF_TICK_US);
	localparam logic [7:0] PSF_SURGE_TICKS = 8'(PSF_SURGE_MS * 1000 / PSF_TICK_US);
	localparam logic [7:0] PSF_SAG_TICKS   = 8'(PSF_SAG_MS * 1000 / PSF_TICK_US);
	localparam logic [7:0] PSF_RETRY_TICKS = 8'(PSF_RETRY_MS * 1000 / PSF_TICK_US);
	localparam logic [7:0] PSF_REARM_TICKS = 8'(PSF_REARM_MS * 1000 / PSF_TICK_US);
	localparam logic [3:0] PSF_RAMP_MAX    = 4'(PSF_RAMP_MS * 1000 / PSF_TICK_US);

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [7:0] PSF_CTRL_OFS   = 8'h00;
	localparam logic [7:0] PSF_STAT_OFS   = 8'h04;
	localparam int         PSF_CTRL_SURGE = 0;
	localparam int         PSF_CTRL_ENHI  = 1;
	localparam logic       PSF_SURGE_RST  = 1'h0;
	localparam logic       PSF_ENHI_RST   = 1'h1;

	typedef enum logic [1:0] {PSF_REG_CTRL, PSF_REG_STAT, PSF_REG_NONE} psf_reg_t;

	typedef enum logic [2:0] {PSF_OFF, PSF_RAMP, PSF_ON, PSF_SAG_OFF, PSF_HOT} psf_sw_t;

	typedef struct packed {
		logic enable;
		logic over_pri;
		logic over_sec;
		logic hot;
		logic cool;
		logic lockout;
		logic sag;
		logic fault_line;
	} psf_flags_t;

	typedef struct packed {
		psf_flags_t  s1;
		psf_flags_t  s2;
		logic [14:0] pre;
		logic        tick;
		logic        surge_en;
		logic        en_high;
		psf_sw_t     st;
		logic        hot;
		logic [7:0]  sag_cnt;
		logic [3:0]  ramp;
		logic [3:0]  gate;
		logic        armed;
		logic        win;
		logic [7:0]  win_cnt;
		logic        lim;
		logic        fault;
		logic [7:0]  flt_cnt;
		logic [31:0] rdata;
	} psf_state_t;

	localparam psf_state_t PSF_STATE_RST = '{
		surge_en: PSF_SURGE_RST,
		en_high:  PSF_ENHI_RST,
		st:       PSF_OFF,
		armed:    1'h1,
		s1:       8'h01,
		s2:       8'h01,
		default:  '0
	};

endpackage : psf_pkg

/* File: hdl/psf_switch_seq.sv */
`timescale 1ns/100ps
// Functional notes
// - fault low on limiting or thermal shutdown
// - plain variant: assert after 32 ms
// - plain variant: release 32 ms after clear
// - surge variant: assert at window end
// - surge variant: only if still over limit
// - surge variant: release 128 ms after clear
// - surge window: secondary limit only
// - window end: back to primary limit
// - plain variant: primary limit at once
// - limiting lasts while overload persists
// - lockout: switch off, functions inert
// - sag monitor only while switched on
// - sag for 32 ms turns switch off
// - switch back on after 128 ms
// - sag retry repeats while sag recurs
// - enable turns on, polarity selectable
// - turn on through soft-start ramp
// - over-temperature: off and fault
// - resume when cool, cycle while hot
// - fault delay between 20 and 49 ms
// - re-arm window after 128 ms unlimited
module psf_switch_seq
	import psf_pkg::*;
#(
	parameter int TICK_CYCLES = PSF_TICK_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_enable,
	input  wire logic        i_over_pri,
	input  wire logic        i_over_sec,
	input  wire logic        i_hot,
	input  wire logic        i_cool,
	input  wire logic        i_supply_lockout,
	input  wire logic        i_input_sag_monitor,
	input  wire logic        i_fault_n_i,
	output logic             o_fault_n_o,
	output logic             o_fault_n_oe,
	output logic             o_switch_on,
	output logic      [3:0]  o_gate_level,
	output logic             o_limit_sec,
	output logic             o_limit_act
);

	////////////////////////////////////////////////////////////////////////
	// state

	psf_state_t q;
	psf_state_t d;
	psf_flags_t s;
	logic       en_req;
	logic       on_d;
	logic       cond;
	logic [7:0] thr;
	psf_reg_t   rsel;

	function automatic psf_reg_t psf_decode(input logic [7:0] a);
		psf_reg_t r;
		r = PSF_REG_NONE;
		if (a == PSF_CTRL_OFS) begin
			r = PSF_REG_CTRL;
		end else if (a == PSF_STAT_OFS) begin
			r = PSF_REG_STAT;
		end
		return r;
	endfunction : psf_decode

	assign rsel = psf_decode(i_paddr);
	assign s    = q.s2;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		thr = 8'h00;
		// only s2 looks at the pins' first stage
		d.s1 = '{i_enable, i_over_pri, i_over_sec, i_hot, i_cool,
			i_supply_lockout, i_input_sag_monitor, i_fault_n_i};
		d.s2 = q.s1;

		// slow time base, 1 ms per tick
		d.tick = (q.pre == 15'(TICK_CYCLES - 1));
		d.pre  = d.tick ? 15'h0000 : q.pre + 15'h0001;

		en_req = (s.enable == q.en_high) && !s.lockout;

		// thermal hysteresis, the comparators carry the 145/135 points
		if (s.lockout) begin
			d.hot = 1'b0;
		end else if (s.hot) begin
			d.hot = 1'b1;
		end else if (s.cool) begin
			d.hot = 1'b0;
		end

		// switch sequencing
		case (q.st)
			PSF_OFF: begin
				d.sag_cnt = 8'h00;
				if (en_req && !q.hot) begin
					d.st   = PSF_RAMP;
					d.ramp = 4'h0;
				end
			end
			PSF_RAMP, PSF_ON: begin
				if (q.st == PSF_RAMP && q.tick) begin
					d.ramp = q.ramp + 4'h1;
					if (q.ramp == PSF_RAMP_MAX - 4'h1) begin
						d.st = PSF_ON;
					end
				end
				// sag monitor is only looked at while switched on
				if (!s.sag) begin
					d.sag_cnt = 8'h00;
				end else if (q.tick) begin
					d.sag_cnt = q.sag_cnt + 8'h01;
				end
				if (!en_req) begin
					d.st = PSF_OFF;
				end else if (q.hot) begin
					d.st = PSF_HOT;
				end else if (q.sag_cnt == PSF_SAG_TICKS) begin
					d.st      = PSF_SAG_OFF;
					d.sag_cnt = 8'h00;
				end
			end
			PSF_SAG_OFF: begin
				if (q.tick) begin
					d.sag_cnt = q.sag_cnt + 8'h01;
				end
				if (!en_req) begin
					d.st = PSF_OFF;
				end else if (q.hot) begin
					d.st = PSF_HOT;
				end else if (q.sag_cnt == PSF_RETRY_TICKS) begin
					d.st      = PSF_RAMP;
					d.ramp    = 4'h0;
					d.sag_cnt = 8'h00;
				end
			end
			PSF_HOT: begin
				d.sag_cnt = 8'h00;
				if (!en_req) begin
					d.st = PSF_OFF;
				end else if (!q.hot) begin
					d.st   = PSF_RAMP;
					d.ramp = 4'h0;
				end
			end
			default: begin
				d.st = PSF_OFF;
			end
		endcase

		on_d = (d.st == PSF_RAMP) || (d.st == PSF_ON);
		case (d.st)
			PSF_RAMP: d.gate = d.ramp;
			PSF_ON:   d.gate = PSF_RAMP_MAX;
			default:  d.gate = 4'h0;
		endcase

		// surge window: opens on first primary overload while armed
		if (!q.surge_en || !on_d) begin
			d.win     = 1'b0;
			d.armed   = 1'b1;
			d.win_cnt = 8'h00;
		end else if (q.win) begin
			if (q.tick) begin
				d.win_cnt = q.win_cnt + 8'h01;
			end
			if (q.win_cnt == PSF_SURGE_TICKS) begin
				d.win     = 1'b0;
				d.win_cnt = 8'h00;
			end
		end else if (q.armed) begin
			if (s.over_pri) begin
				d.win     = 1'b1;
				d.armed   = 1'b0;
				d.win_cnt = 8'h00;
			end
		end else begin
			// re-arm only after a quiet stretch out of limiting
			if (s.over_pri) begin
				d.win_cnt = 8'h00;
			end else if (q.tick) begin
				d.win_cnt = q.win_cnt + 8'h01;
			end
			if (q.win_cnt == PSF_REARM_TICKS) begin
				d.armed   = 1'b1;
				d.win_cnt = 8'h00;
			end
		end

		// clamp follows the comparator, so it ends with the overload
		d.lim = on_d && (d.win ? s.over_sec : s.over_pri);

		// fault filter; surge variant already waited out the window
		cond = (q.lim && !q.win) || q.hot;
		if (q.fault) begin
			thr = q.surge_en ? PSF_SURGE_TICKS : PSF_FLT_TICKS;
		end else begin
			thr = q.surge_en ? 8'h00 : PSF_FLT_TICKS;
		end
		if (s.lockout) begin
			d.fault   = 1'b0;
			d.flt_cnt = 8'h00;
		end else if (cond == q.fault) begin
			d.flt_cnt = 8'h00;
		end else if (q.flt_cnt >= thr) begin
			d.fault   = cond;
			d.flt_cnt = 8'h00;
		end else if (q.tick) begin
			d.flt_cnt = q.flt_cnt + 8'h01;
		end

		// apb: write in access phase, read data latched in setup
		if (i_psel && i_penable && i_pwrite && rsel == PSF_REG_CTRL) begin
			d.surge_en = i_pwdata[PSF_CTRL_SURGE];
			d.en_high  = i_pwdata[PSF_CTRL_ENHI];
		end
		if (i_psel && !i_penable) begin
			d.rdata = 32'h0000_0000;
			case (rsel)
				PSF_REG_CTRL: begin
					d.rdata[PSF_CTRL_SURGE] = q.surge_en;
					d.rdata[PSF_CTRL_ENHI]  = q.en_high;
				end
				PSF_REG_STAT: begin
					d.rdata[15:0] = {1'b0, q.st, q.gate, !s.fault_line,
						s.lockout, q.lim, q.win, q.hot, q.fault,
						(q.st == PSF_SAG_OFF), (q.st == PSF_ON)};
				end
				default: d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q <= PSF_STATE_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_prdata     = q.rdata;
	assign o_pready     = 1'b1;
	assign o_pslverr    = i_psel && i_penable && (rsel == PSF_REG_NONE);
	// open drain: pull-up and wired-or belong to the board
	assign o_fault_n_o  = 1'b0;
	assign o_fault_n_oe = q.fault;
	assign o_switch_on  = (q.st == PSF_RAMP) || (q.st == PSF_ON);
	assign o_gate_level = q.gate;
	assign o_limit_sec  = q.win;
	assign o_limit_act  = q.lim;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	a_lockout_switch: assert property (s.lockout |=> !o_switch_on)
		else $error("switch on during supply lockout");

	a_lockout_fault: assert property (s.lockout |=> !o_fault_n_oe)
		else $error("fault driven during supply lockout");

	a_hot_switch: assert property (q.hot |=> !o_switch_on)
		else $error("switch on in thermal shutdown");

	a_fault_assert_dly: assert property ($rose(q.fault) && !q.surge_en
		|-> $past(q.flt_cnt) == PSF_FLT_TICKS)
		else $error("fault asserted without full filter delay");

	a_fault_release_dly: assert property ($fell(q.fault) && !$past(s.lockout)
		|-> $past(q.flt_cnt) == (q.surge_en ? PSF_SURGE_TICKS : PSF_FLT_TICKS))
		else $error("fault released early");

	a_surge_length: assert property ($fell(q.win) && o_switch_on
		|-> $past(q.win_cnt) == PSF_SURGE_TICKS)
		else $error("surge window length wrong");

	a_sag_trip: assert property ($rose(q.st == PSF_SAG_OFF)
		|-> $past(q.sag_cnt) == PSF_SAG_TICKS)
		else $error("sag trip at wrong count");

	a_sag_retry: assert property ($past(q.st) == PSF_SAG_OFF && q.st == PSF_RAMP
		|-> $past(q.sag_cnt) == PSF_RETRY_TICKS)
		else $error("sag retry at wrong time");

	a_plain_limit: assert property (!q.surge_en && s.over_pri && o_switch_on
		##1 o_switch_on && !q.surge_en |-> o_limit_act && !o_limit_sec)
		else $error("primary limit not applied at once");

	a_ramp_first: assert property ($rose(o_switch_on) |-> q.st == PSF_RAMP
		&& q.gate == 4'h0)
		else $error("switch on without soft start");

endmodule : psf_switch_seq

/* File: sim/psf_host_model.sv */
`timescale 1ns/100ps
module psf_host_model (
	input  wire logic i_clk,
	input  wire logic i_en_cmd,
	input  wire logic i_fault_n_o,
	input  wire logic i_fault_n_oe,
	input  wire logic i_other_oe,
	output logic      o_enable,
	output logic      o_fault_line
);
	// host register drives enable; unknown only until the first edge, inside reset
	always @(posedge i_clk) o_enable <= i_en_cmd;
	// pull-up resistor; a second open-drain output shares the line
	assign o_fault_line = (i_fault_n_oe ? i_fault_n_o : 1'h1) & ~i_other_oe;
endmodule : psf_host_model

/* File: sim/tb_power_switch_fault_sequencer.sv */
`timescale 1ns/100ps
module tb_power_switch_fault_sequencer import psf_pkg::*;;
	// short time base keeps the long intervals cheap
	localparam int TK = 4;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic        en_cmd, en, fl, other, oe, fo, sw, lsec, lact;
	logic        over_pri, over_sec, hot, cool, lock, sag;
	logic [7:0]  paddr;
	logic [3:0]  gate;
	logic [31:0] pwdata, prdata, rd;
	int          fails, cmp_count, n;

	psf_switch_seq #(.TICK_CYCLES(TK)) uut (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_enable(en),
		.i_over_pri(over_pri), .i_over_sec(over_sec), .i_hot(hot), .i_cool(cool),
		.i_supply_lockout(lock), .i_input_sag_monitor(sag), .i_fault_n_i(fl),
		.o_fault_n_o(fo), .o_fault_n_oe(oe), .o_switch_on(sw), .o_gate_level(gate),
		.o_limit_sec(lsec), .o_limit_act(lact));
	psf_host_model host (.i_clk(clk), .i_en_cmd(en_cmd), .i_fault_n_o(fo),
		.i_fault_n_oe(oe), .i_other_oe(other), .o_enable(en), .o_fault_line(fl));

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic bad(input string m);
		fails++;
		$display("MISMATCH %0t %s", $time, m);
	endtask : bad
	task automatic chk1(input logic g, input logic e, input string m);
		cmp_count++;
		if (g !== e) bad(m);
	endtask : chk1
	task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
		cmp_count++;
		if (g !== e) bad(m);
	endtask : chk32
	task automatic chkn(input int g, input int lo, input int hi, input string m);
		cmp_count++;
		if (g < lo || g > hi) bad(m);
	endtask : chkn
	function automatic logic sig(input int k);
		case (k)
			0: return oe;
			1: return sw;
			2: return lsec;
			default: return lact;
		endcase
	endfunction : sig
	// bounded wait; a must-wait that runs out ends the run
	task automatic wt(input int k, input logic v, input int mx, input bit must, output int c);
		c = 0;
		if (must) cmp_count++;
		while (sig(k) !== v && c < mx) begin
			@(posedge clk);
			c++;
		end
		if (must && c >= mx) begin
			bad("wait timed out");
			summarize();
		end
	endtask : wt
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int c;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (pready !== 1'h1 && c < 50);
		if (c >= 50) begin
			bad("apb timed out");
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, en_cmd, other, over_pri, over_sec} = '0;
		{hot, cool, lock, sag, arst_n} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		arst_n <= 1'h1;
		apb(1'h0, PSF_CTRL_OFS, 32'h0);
		chk32(rd, 32'h2, "ctrl reset value");
		apb(1'h0, 8'h08, 32'h0);
		chk1(err, 1'h1, "unmapped error");
		en_cmd <= 1'h1;
		wt(1, 1'h1, 20, 1, n);
		chk1(gate != 4'hf, 1'h1, "gate not ramping");
		repeat (20 * TK) @(posedge clk);
		apb(1'h0, PSF_STAT_OFS, 32'h0);
		chk32(rd & 32'hf01, 32'hf01, "not fully on");
		chk1(gate == 4'hf, 1'h1, "gate not at top");
		// plain variant current limit and fault filter
		over_pri <= 1'h1;
		wt(3, 1'h1, 10, 1, n);
		wt(0, 1'h1, 300, 1, n);
		chkn(n, 20 * TK, 49 * TK, "assert delay");
		chk1(fo, 1'h0, "fault drive level");
		chk1(lact, 1'h1, "limit dropped");
		other <= 1'h1;
		apb(1'h0, PSF_STAT_OFS, 32'h0);
		chk32(rd & 32'h80, 32'h80, "shared line");
		other <= 1'h0;
		over_pri <= 1'h0;
		wt(0, 1'h0, 300, 1, n);
		chkn(n, 20 * TK, 49 * TK, "release delay");
		// another output pulls the shared line while this one is released
		other <= 1'h1;
		repeat (4) @(posedge clk);
		chk1(oe, 1'h0, "fault from shared line");
		apb(1'h0, PSF_STAT_OFS, 32'h0);
		chk32(rd & 32'h84, 32'h80, "shared line low");
		other <= 1'h0;
		// thermal cycling, twice
		for (int i = 0; i < 2; i++) begin
			hot <= 1'h1;
			wt(1, 1'h0, 10, 1, n);
			wt(0, 1'h1, 300, 1, n);
			hot <= 1'h0;
			cool <= 1'h1;
			wt(1, 1'h1, 10, 1, n);
			cool <= 1'h0;
		end
		wt(0, 1'h0, 300, 1, n);
		// sag ignored while off, then off and retry cycles
		en_cmd <= 1'h0;
		wt(1, 1'h0, 10, 1, n);
		sag <= 1'h1;
		repeat (40 * TK) @(posedge clk);
		en_cmd <= 1'h1;
		wt(1, 1'h1, 20, 1, n);
		for (int i = 0; i < 2; i++) begin
			wt(1, 1'h0, 200, 1, n);
			chkn(n, 31 * TK, 35 * TK, "sag off time");
			wt(1, 1'h1, 700, 1, n);
			chkn(n, 126 * TK, 132 * TK, "retry time");
		end
		sag <= 1'h0;
		// lockout holds switch off and fault inert
		lock <= 1'h1;
		wt(1, 1'h0, 6, 1, n);
		over_pri <= 1'h1;
		repeat (60 * TK) @(posedge clk);
		chk1(sw, 1'h0, "lockout on");
		chk1(oe, 1'h0, "lockout fault");
		over_pri <= 1'h0;
		lock <= 1'h0;
		wt(1, 1'h1, 10, 1, n);
		// low-true enable
		apb(1'h1, PSF_CTRL_OFS, 32'h0);
		wt(1, 1'h0, 10, 1, n);
		en_cmd <= 1'h0;
		wt(1, 1'h1, 10, 1, n);
		// surge window variant
		apb(1'h1, PSF_CTRL_OFS, 32'h1);
		repeat (20 * TK) @(posedge clk);
		over_pri <= 1'h1;
		over_sec <= 1'h1;
		wt(2, 1'h1, 10, 1, n);
		repeat (2) @(posedge clk);
		chk1(lact, 1'h1, "secondary clamp");
		wt(0, 1'h1, 900, 1, n);
		chkn(n, 77 * TK, 192 * TK, "surge assert");
		chk1(lsec, 1'h0, "window not closed");
		over_pri <= 1'h0;
		over_sec <= 1'h0;
		wt(0, 1'h0, 900, 1, n);
		chkn(n, 77 * TK, 192 * TK, "surge release");
		over_pri <= 1'h1;
		wt(2, 1'h1, 10, 1, n);
		repeat (20 * TK) @(posedge clk);
		over_pri <= 1'h0;
		wt(0, 1'h1, 200 * TK, 0, n);
		chkn(n, 200 * TK, 200 * TK, "short surge fault");
		summarize();
	end
endmodule : tb_power_switch_fault_sequencer
